// file: hw/icunm_top.sv
// Interrupt controller with non-maskable merge and wake-up logic
`timescale 1ns/100ps
module icunm_top (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic [icunm_pkg::NUM_VEC-1:0] SRC_REQ,
   input wire logic [icunm_pkg::NUM_PINS-1:0] IRQ_PIN,
   input wire logic [2*icunm_pkg::NUM_PINS-1:0] IRQ_MODE,
   input wire logic [icunm_pkg::NUM_PINS-1:0] IRQ_FILT_EN,
   input wire logic NMI_PIN,
   input wire logic NMI_EDGE_RISE,
   input wire logic NMI_FILT_EN,
   input wire logic OSC_STOP,
   input wire logic INDEPENDENT_WATCHDOG_UNDERFLOW,
   input wire logic INDEPENDENT_WATCHDOG_REFRESH_ERR,
   input wire logic VMON1_INT,
   input wire logic VMON2_INT,
   input wire logic [icunm_pkg::NUM_NMI-1:0] NMI_EN,
   input wire logic [icunm_pkg::NUM_NMI-1:0] NMI_CLR,
   input wire logic CFG_WR,
   input wire logic [1:0] CFG_KIND,
   input wire logic [icunm_pkg::VEC_W-1:0] CFG_VEC,
   input wire logic [icunm_pkg::PRIO_W-1:0] CFG_DATA,
   input wire logic FAST_EN,
   input wire logic [icunm_pkg::VEC_W-1:0] FAST_VEC,
   input wire logic CPU_ACK,
   input wire logic XFER_ACK,
   input wire logic [1:0] LP_MODE,
   output logic CPU_IRQ,
   output logic CPU_FAST,
   output logic [icunm_pkg::VEC_W-1:0] CPU_VEC,
   output logic [icunm_pkg::PRIO_W-1:0] CPU_LVL,
   output logic DTC_REQ,
   output logic DMA_REQ,
   output logic [icunm_pkg::VEC_W-1:0] XFER_VEC,
   output logic NMI_REQ,
   output logic [icunm_pkg::NUM_NMI-1:0] NMI_STATUS,
   output logic WAKE_REQ
);
   import icunm_pkg::*;

   localparam int NDET = NUM_PINS + 1;

   icunm_arb_if arb_bus ();

   logic [NUM_VEC-1:0] pend_q;
   logic [NUM_VEC-1:0] xfer_en_q;
   logic [NUM_VEC-1:0] xfer_dma_q;
   logic [PRIO_W-1:0] prio_q [NUM_VEC];
   logic [NUM_NMI-1:0] nmi_st_q;
   logic [NUM_NMI-1:0] nmi_set;
   logic [NDET-1:0] det;
   logic [2*NDET-1:0] det_mode;
   logic [NUM_VEC-1:0] src_set;
   logic [NUM_VEC-1:0] src_clr;
   logic fast_pend;
   logic any_enabled;
   logic nmi_any;

   ////////////////////////////////////////////////////////////////////////
   // Constants the vector decode relies on; bad values stop elaboration
   if ((1 << VEC_W) != NUM_VEC) begin : g_chk_width
      $error("icunm_top: vector width must address every vector");
   end
   if (PEND_FIRST > XFER_FIRST || RSVD_FIRST > NUM_VEC) begin : g_chk_range
      $error("icunm_top: vector ranges out of order");
   end
   if (PIN_VEC_BASE < PEND_FIRST || PIN_VEC_BASE + NUM_PINS > RSVD_FIRST) begin : g_chk_pin
      $error("icunm_top: pin vectors must have pending bits");
   end
   // Transfer routing keeps its two control bits in the data field
   if (PRIO_W < 2) begin : g_chk_data
      $error("icunm_top: data field too narrow for transfer routing");
   end
   if (NUM_NMI != NMI_B_VMON2 + 1) begin : g_chk_nmi
      $error("icunm_top: non-maskable status word size mismatch");
   end

   ////////////////////////////////////////////////////////////////////////
   // Vector ranges that carry each per-vector register
   function automatic logic has_pend(input int v);
      has_pend = (v >= PEND_FIRST) && (v < RSVD_FIRST);
   endfunction : has_pend

   function automatic logic has_xfer(input int v);
      has_xfer = (v >= XFER_FIRST) && (v < RSVD_FIRST);
   endfunction : has_xfer

   ////////////////////////////////////////////////////////////////////////
   // Pin detection: eight external pins plus the non-maskable pin
   assign det_mode = {(NMI_EDGE_RISE ? DET_RISE : DET_FALL), IRQ_MODE};

   icunm_pin_detect #(
      .N(NDET)
   ) u_pins (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .pin({NMI_PIN, IRQ_PIN}),
      .mode(det_mode),
      .filt_en({NMI_FILT_EN, IRQ_FILT_EN}),
      .det(det)
   );

   ////////////////////////////////////////////////////////////////////////
   // Request set and clear terms
   always_comb begin
      src_set = '0;
      src_clr = '0;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (has_pend(v)) begin
            src_set[v] = SRC_REQ[v];
         end
      end
      for (int p = 0; p < NUM_PINS; p++) begin
         src_set[PIN_VEC_BASE + p] = det[p];
      end
      if (CPU_ACK && CPU_IRQ) begin
         src_clr[CPU_VEC] = 1'b1;
      end
      if (XFER_ACK && (DTC_REQ || DMA_REQ)) begin
         src_clr[XFER_VEC] = 1'b1;
      end
      if (CFG_WR && CFG_KIND == CFG_CLR) begin
         src_clr[CFG_VEC] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending store; a new request beats a clear in the same cycle
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pend_q <= '0;
      end else begin
         for (int v = 0; v < NUM_VEC; v++) begin
            if (!has_pend(v)) begin
               pend_q[v] <= 1'b0;
            end else if (src_set[v]) begin
               pend_q[v] <= 1'b1;
            end else if (src_clr[v]) begin
               pend_q[v] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-vector priority levels
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int v = 0; v < NUM_VEC; v++) begin
            prio_q[v] <= PRIO_RST;
         end
      end else if (CFG_WR && CFG_KIND == CFG_PRIO) begin
         // Reserved slots stay at zero so they can never win
         if (CFG_VEC < VEC_W'(RSVD_FIRST)) begin
            prio_q[CFG_VEC] <= CFG_DATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-vector transfer routing: bit 0 enables, bit 1 picks DMA
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         xfer_en_q <= '0;
         xfer_dma_q <= '0;
      end else if (CFG_WR && CFG_KIND == CFG_XFER) begin
         for (int v = 0; v < NUM_VEC; v++) begin
            if (has_xfer(v) && CFG_VEC == VEC_W'(v)) begin
               xfer_en_q[v] <= CFG_DATA[0];
               xfer_dma_q[v] <= CFG_DATA[1];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbitration
   assign arb_bus.pend = pend_q;
   assign arb_bus.xfer_en = xfer_en_q;
   assign arb_bus.prio = prio_q;

   icunm_arbiter u_arb (
      .bus(arb_bus)
   );

   // The one fast vector preempts normal arbitration while it is pending, not routed to transfer, and at a nonzero level
   assign fast_pend = FAST_EN && pend_q[FAST_VEC] && !xfer_en_q[FAST_VEC]
      && prio_q[FAST_VEC] != PRIO_RST;

   ////////////////////////////////////////////////////////////////////////
   // CPU request outputs; an ack drops the request for one cycle
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         CPU_IRQ <= 1'b0;
         CPU_FAST <= 1'b0;
         CPU_VEC <= VEC_RST;
         CPU_LVL <= PRIO_RST;
      end else if (CPU_ACK && CPU_IRQ) begin
         CPU_IRQ <= 1'b0;
         CPU_FAST <= 1'b0;
      end else if (fast_pend) begin
         CPU_IRQ <= 1'b1;
         CPU_FAST <= 1'b1;
         CPU_VEC <= FAST_VEC;
         CPU_LVL <= prio_q[FAST_VEC];
      end else begin
         CPU_IRQ <= arb_bus.cpu_hit;
         CPU_FAST <= 1'b0;
         CPU_VEC <= arb_bus.cpu_vec;
         CPU_LVL <= arb_bus.cpu_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer controller activation
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         DTC_REQ <= 1'b0;
         DMA_REQ <= 1'b0;
         XFER_VEC <= VEC_RST;
      end else if (XFER_ACK && (DTC_REQ || DMA_REQ)) begin
         DTC_REQ <= 1'b0;
         DMA_REQ <= 1'b0;
      end else begin
         DTC_REQ <= arb_bus.xfer_hit && !xfer_dma_q[arb_bus.xfer_vec];
         DMA_REQ <= arb_bus.xfer_hit && xfer_dma_q[arb_bus.xfer_vec];
         XFER_VEC <= arb_bus.xfer_vec;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Non-maskable sources
   always_comb begin
      nmi_set = '0;
      nmi_set[NMI_B_PIN] = det[NUM_PINS];
      nmi_set[NMI_B_OSC] = OSC_STOP;
      nmi_set[NMI_B_INDEPENDENT_WATCHDOG] = INDEPENDENT_WATCHDOG_UNDERFLOW | INDEPENDENT_WATCHDOG_REFRESH_ERR;
      nmi_set[NMI_B_VMON1] = VMON1_INT;
      nmi_set[NMI_B_VMON2] = VMON2_INT;
   end

   // Sticky flags; a fresh event wins over a clear
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         nmi_st_q <= '0;
      end else begin
         nmi_st_q <= nmi_set | (nmi_st_q & ~NMI_CLR);
      end
   end

   assign nmi_any = |(nmi_st_q & NMI_EN);

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         NMI_REQ <= 1'b0;
         NMI_STATUS <= '0;
      end else begin
         NMI_REQ <= nmi_any;
         NMI_STATUS <= nmi_st_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake-up from low power states
   always_comb begin
      any_enabled = 1'b0;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (pend_q[v] && prio_q[v] != PRIO_RST) begin
            any_enabled = 1'b1;
         end
      end
   end

   // Standby stops most clocks, so only pins and non-maskable events count
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         WAKE_REQ <= 1'b0;
      end else begin
         unique case (icunm_lp_t'(LP_MODE))
            LP_RUN: WAKE_REQ <= 1'b0;
            LP_SLEEP: WAKE_REQ <= nmi_any || any_enabled;
            LP_DEEP: WAKE_REQ <= nmi_any || any_enabled;
            LP_STBY: WAKE_REQ <= nmi_any || (|det[NUM_PINS-1:0]);
         endcase
      end
   end
endmodule : icunm_top

// file: shared/icunm_pkg.sv
// Shared constants and types for the interrupt controller
package icunm_pkg;
   localparam int NUM_VEC = 256;
   localparam int VEC_W = 8;
   localparam int PRIO_W = 4;
   localparam int NUM_PINS = 8;
   localparam int PEND_FIRST = 16;
   localparam int XFER_FIRST = 27;
   localparam int RSVD_FIRST = 250;
   localparam int PIN_VEC_BASE = 64;
   localparam int FILT_LEN = 3;
   localparam int NUM_NMI = 5;
   // Non-maskable status bit positions
   localparam int NMI_B_PIN = 0;
   localparam int NMI_B_OSC = 1;
   localparam int NMI_B_INDEPENDENT_WATCHDOG = 2;
   localparam int NMI_B_VMON1 = 3;
   localparam int NMI_B_VMON2 = 4;
   // Configuration write kinds
   localparam logic [1:0] CFG_PRIO = 2'h0;
   localparam logic [1:0] CFG_XFER = 2'h1;
   localparam logic [1:0] CFG_CLR = 2'h2;
   localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
   localparam logic [VEC_W-1:0] VEC_RST = 8'h00;
   // Pin detection modes
   typedef enum logic [1:0] {
      DET_LOW = 2'h0,
      DET_FALL = 2'h1,
      DET_RISE = 2'h2,
      DET_BOTH = 2'h3
   } icunm_det_t;
   // Core power states
   typedef enum logic [1:0] {
      LP_RUN = 2'h0,
      LP_SLEEP = 2'h1,
      LP_DEEP = 2'h2,
      LP_STBY = 2'h3
   } icunm_lp_t;
endpackage : icunm_pkg

// file: shared/icunm_arb_if.sv
// Carrier between the request store and the priority arbiter
`timescale 1ns/100ps
interface icunm_arb_if;
   import icunm_pkg::*;
   logic [NUM_VEC-1:0] pend;
   logic [NUM_VEC-1:0] xfer_en;
   logic [PRIO_W-1:0] prio [NUM_VEC];
   logic cpu_hit;
   logic [VEC_W-1:0] cpu_vec;
   logic [PRIO_W-1:0] cpu_lvl;
   logic xfer_hit;
   logic [VEC_W-1:0] xfer_vec;
   modport store (output pend, xfer_en, prio, input cpu_hit, cpu_vec, cpu_lvl,
      xfer_hit, xfer_vec);
   modport arb (input pend, xfer_en, prio, output cpu_hit, cpu_vec, cpu_lvl,
      xfer_hit, xfer_vec);
endinterface : icunm_arb_if

// file: hw/icunm_pin_detect.sv
// Synchroniser, noise filter and edge or level detector for pins
`timescale 1ns/100ps
module icunm_pin_detect #(
   parameter int N = 9
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [N-1:0] pin,
   input wire logic [2*N-1:0] mode,
   input wire logic [N-1:0] filt_en,
   output logic [N-1:0] det
);
   import icunm_pkg::*;

   if (N < 1) begin : g_chk
      $error("icunm_pin_detect: N must be at least 1");
   end

   logic [N-1:0] sync1_q;
   logic [N-1:0] sync2_q;
   logic [N-1:0] lvl_q;

   ////////////////////////////////////////////////////////////////////////
   // Two stages before anything looks at a pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   for (genvar i = 0; i < N; i++) begin : g_pin
      logic [FILT_LEN-1:0] hist_q;
      logic filt;
      logic [1:0] m;
      // Filter trades latency for glitch immunity
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            hist_q <= '1;
            lvl_q[i] <= 1'b1;
         end else begin
            hist_q <= {hist_q[FILT_LEN-2:0], sync2_q[i]};
            lvl_q[i] <= filt;
         end
      end
      always_comb begin
         filt = lvl_q[i];
         if (!filt_en[i]) begin
            filt = sync2_q[i];
         end else if (&hist_q) begin
            filt = 1'b1;
         end else if (~|hist_q) begin
            filt = 1'b0;
         end
      end
      assign m = mode[2*i +: 2];
      always_comb begin
         unique case (m)
            DET_LOW: det[i] = ~filt;
            DET_FALL: det[i] = lvl_q[i] & ~filt;
            DET_RISE: det[i] = ~lvl_q[i] & filt;
            DET_BOTH: det[i] = lvl_q[i] ^ filt;
         endcase
      end
   end
endmodule : icunm_pin_detect

// file: hw/icunm_arbiter.sv
// Priority arbiter for CPU and transfer-controller requests
`timescale 1ns/100ps
module icunm_arbiter (
   icunm_arb_if.arb bus
);
   import icunm_pkg::*;

   function automatic logic usable(input int v);
      usable = (v >= PEND_FIRST) && (v < RSVD_FIRST);
   endfunction : usable

   ////////////////////////////////////////////////////////////////////////
   // Highest level wins; ties go to the lowest vector
   always_comb begin
      bus.cpu_hit = 1'b0;
      bus.cpu_vec = VEC_RST;
      bus.cpu_lvl = PRIO_RST;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (usable(v) && bus.pend[v] && !bus.xfer_en[v]
            && bus.prio[v] > bus.cpu_lvl) begin
            bus.cpu_hit = 1'b1;
            bus.cpu_vec = VEC_W'(v);
            bus.cpu_lvl = bus.prio[v];
         end
      end
   end

   // Transfer routing ignores level zero, same as the CPU path
   always_comb begin
      bus.xfer_hit = 1'b0;
      bus.xfer_vec = VEC_RST;
      for (int v = NUM_VEC - 1; v >= XFER_FIRST; v--) begin
         if (usable(v) && bus.pend[v] && bus.xfer_en[v] && bus.prio[v] != PRIO_RST) begin
            bus.xfer_hit = 1'b1;
            bus.xfer_vec = VEC_W'(v);
         end
      end
   end
endmodule : icunm_arbiter

// file: tb/icunm_checker.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/100ps
module icunm_checker
   import icunm_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic OSC_STOP,
   input wire logic INDEPENDENT_WATCHDOG_UNDERFLOW,
   input wire logic INDEPENDENT_WATCHDOG_REFRESH_ERR,
   input wire logic [icunm_pkg::NUM_NMI-1:0] NMI_CLR,
   input wire logic [icunm_pkg::NUM_NMI-1:0] NMI_STATUS,
   input wire logic NMI_REQ,
   input wire logic CPU_ACK,
   input wire logic CPU_IRQ,
   input wire logic CPU_FAST,
   input wire logic [icunm_pkg::VEC_W-1:0] CPU_VEC,
   input wire logic [icunm_pkg::PRIO_W-1:0] CPU_LVL,
   input wire logic DTC_REQ,
   input wire logic DMA_REQ,
   input wire logic [icunm_pkg::VEC_W-1:0] XFER_VEC,
   input wire logic [1:0] LP_MODE,
   input wire logic WAKE_REQ
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   ////////////////////////////////////////
   osc_flag_a: assert property (OSC_STOP |-> ##2 NMI_STATUS[NMI_B_OSC])
      else $error("osc stop flag missing");
   wdt_flag_a: assert property ((INDEPENDENT_WATCHDOG_UNDERFLOW || INDEPENDENT_WATCHDOG_REFRESH_ERR)
      |-> ##2 NMI_STATUS[NMI_B_INDEPENDENT_WATCHDOG]) else $error("watchdog flag missing");
   flag_hold_a: assert property ($fell(NMI_STATUS[NMI_B_OSC])
      |-> $past(NMI_CLR[NMI_B_OSC], 2)) else $error("flag dropped uncleared");
   nmi_off_a: assert property (NMI_STATUS == 5'h00 |-> !NMI_REQ)
      else $error("nmi without flag");
   ack_drop_a: assert property (CPU_IRQ && CPU_ACK |=> !CPU_IRQ)
      else $error("irq kept after ack");
   lvl_set_a: assert property (CPU_IRQ |-> CPU_LVL != 4'h0 && CPU_VEC < 8'hFA)
      else $error("bad cpu level or vector");
   xfer_path_a: assert property ((DTC_REQ || DMA_REQ)
      |-> !(DTC_REQ && DMA_REQ) && XFER_VEC inside {[8'h1B:8'hF9]})
      else $error("bad transfer request");
   fast_a: assert property (CPU_FAST |-> CPU_IRQ)
      else $error("fast flag without irq");
   run_wake_a: assert property (LP_MODE == LP_RUN ##1 LP_MODE == LP_RUN |-> !WAKE_REQ)
      else $error("wake while running");
   cover property (CPU_IRQ && CPU_ACK);
   cover property (CPU_FAST);
   cover property ($rose(WAKE_REQ));
endmodule : icunm_checker
bind icunm_top icunm_checker i_icunm_checker (.*);

// file: tb/icunm_cpu_model.sv
// Behavioural model of the CPU core and transfer controllers
`timescale 1ns/100ps
module icunm_cpu_model #(
   parameter int DLY = 2
) (
   input wire logic clk,
   input wire logic hold,
   input wire logic cpu_irq,
   input wire logic cpu_fast,
   input wire logic [icunm_pkg::VEC_W-1:0] cpu_vec,
   input wire logic dtc_req,
   input wire logic dma_req,
   input wire logic [icunm_pkg::VEC_W-1:0] xfer_vec,
   output logic cpu_ack,
   output logic xfer_ack,
   output logic [9:0] got,
   output int n_got
);
   import icunm_pkg::*;
   int wait_q = 0;
   initial begin
      cpu_ack = 1'b0;
      xfer_ack = 1'b0;
      got = 10'h000;
      n_got = 0;
   end
   ////////////////////////////////////////
   // One take per handshake; hold stalls like a busy core
   // A take counts at the edge where the block sees the ack with its request up
   always @(posedge clk) begin
      cpu_ack <= 1'b0;
      xfer_ack <= 1'b0;
      if (cpu_ack && cpu_irq) begin
         n_got <= n_got + 1;
         got <= {1'b0, cpu_fast, cpu_vec};
      end
      if (xfer_ack && (dtc_req || dma_req)) begin
         n_got <= n_got + 1;
         got <= {1'b1, dma_req, xfer_vec};
      end
      if (hold || cpu_ack || xfer_ack || !(cpu_irq || dtc_req || dma_req)) begin
         wait_q <= 0;
      end else if (wait_q < DLY) begin
         wait_q <= wait_q + 1;
      end else begin
         wait_q <= 0;
         if (cpu_irq) begin
            cpu_ack <= 1'b1;
         end else begin
            xfer_ack <= 1'b1;
         end
      end
   end
endmodule : icunm_cpu_model

// file: tb/icunm_top_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module icunm_top_tb;
   import icunm_pkg::*;
   logic CORE_CLK = 1'b0, RST_B = 1'b0, NMI_PIN = 1'b1, NMI_EDGE_RISE = 1'b0;
   logic NMI_FILT_EN = 1'b0, OSC_STOP = 1'b0, INDEPENDENT_WATCHDOG_UNDERFLOW = 1'b0, INDEPENDENT_WATCHDOG_REFRESH_ERR = 1'b0;
   logic VMON1_INT = 1'b0, VMON2_INT = 1'b0, CFG_WR = 1'b0, FAST_EN = 1'b0, hold = 1'b0;
   logic [NUM_VEC-1:0] SRC_REQ = '0;
   logic [NUM_PINS-1:0] IRQ_PIN = 8'hFF, IRQ_FILT_EN = 8'h08;
   logic [2*NUM_PINS-1:0] IRQ_MODE = 16'h0000;
   logic [NUM_NMI-1:0] NMI_EN = 5'h00, NMI_CLR = 5'h00, NMI_STATUS;
   logic [1:0] CFG_KIND = 2'h0, LP_MODE = 2'h0;
   logic [VEC_W-1:0] CFG_VEC = 8'h00, FAST_VEC = 8'h00, CPU_VEC, XFER_VEC;
   logic [PRIO_W-1:0] CFG_DATA = 4'h0, CPU_LVL;
   logic CPU_ACK, XFER_ACK, CPU_IRQ, CPU_FAST, DTC_REQ, DMA_REQ, NMI_REQ, WAKE_REQ;
   logic [9:0] got;
   int n_got, n_mismatch = 0, checks = 0;
   always #10 CORE_CLK = ~CORE_CLK;
   icunm_top i_icunm_top (.*);
   icunm_cpu_model #(.DLY(2)) i_icunm_cpu_model (.clk(CORE_CLK), .hold(hold),
      .cpu_irq(CPU_IRQ), .cpu_fast(CPU_FAST), .cpu_vec(CPU_VEC), .dtc_req(DTC_REQ),
      .dma_req(DMA_REQ), .xfer_vec(XFER_VEC), .cpu_ack(CPU_ACK), .xfer_ack(XFER_ACK),
      .got(got), .n_got(n_got));
   ////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   // Checks land at the falling edge, clear of the design's updates
   task automatic settle(input int n);
      repeat (n) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
   endtask : settle
   task automatic cfg(input logic [1:0] k, input logic [7:0] v, input logic [3:0] d);
      @(posedge CORE_CLK);
      CFG_WR <= 1'b1;
      CFG_KIND <= k;
      CFG_VEC <= v;
      CFG_DATA <= d;
      @(posedge CORE_CLK);
      CFG_WR <= 1'b0;
   endtask : cfg
   task automatic req(input logic [NUM_VEC-1:0] m);
      @(posedge CORE_CLK);
      SRC_REQ <= m;
      @(posedge CORE_CLK);
      SRC_REQ <= '0;
   endtask : req
   task automatic take(input logic [9:0] exp);
      int n0;
      n0 = n_got;
      for (int i = 0; i < 40 && n_got == n0; i++) @(negedge CORE_CLK);
      chk(16'(n_got - n0), 16'h0001);
      chk(16'(got), 16'(exp));
   endtask : take
   task automatic quiet(input int n);
      int n0;
      n0 = n_got;
      settle(n);
      chk(16'(n_got - n0), 16'h0000);
   endtask : quiet
   task automatic nclr;
      @(posedge CORE_CLK);
      NMI_CLR <= 5'h1F;
      @(posedge CORE_CLK);
      NMI_CLR <= 5'h00;
      settle(2);
   endtask : nclr
   ////////////////////////////////////////
   task automatic t_prio;
      cfg(CFG_PRIO, 8'h14, 4'h3);
      cfg(CFG_PRIO, 8'h28, 4'h7);
      cfg(CFG_PRIO, 8'hF9, 4'h7);
      req((256'h1 << 8'h14) | (256'h1 << 8'h28) | (256'h1 << 8'hF9));
      take(10'h028);
      take(10'h0F9);
      take(10'h014);
      req(256'h1 << 8'h32);
      quiet(10);
      cfg(CFG_PRIO, 8'hFC, 4'hF);
      req(256'h1 << 8'hFC);
      quiet(10);
   endtask : t_prio
   task automatic t_fast;
      @(posedge CORE_CLK);
      FAST_EN <= 1'b1;
      FAST_VEC <= 8'h1E;
      cfg(CFG_PRIO, 8'h1E, 4'h1);
      cfg(CFG_PRIO, 8'h1F, 4'h9);
      req((256'h1 << 8'h1E) | (256'h1 << 8'h1F));
      take(10'h11E);
      take(10'h01F);
   endtask : t_fast
   task automatic t_xfer;
      cfg(CFG_XFER, 8'h28, 4'h1);
      cfg(CFG_XFER, 8'h3C, 4'h3);
      cfg(CFG_XFER, 8'h1A, 4'h1);
      cfg(CFG_XFER, 8'h1B, 4'h1);
      cfg(CFG_PRIO, 8'h3C, 4'h2);
      cfg(CFG_PRIO, 8'h1A, 4'h2);
      cfg(CFG_PRIO, 8'h1B, 4'h1);
      req(256'h1 << 8'h28);
      take(10'h228);
      req(256'h1 << 8'h3C);
      take(10'h33C);
      req(256'h1 << 8'h1A);
      take(10'h01A);
      req(256'h1 << 8'h1B);
      take(10'h21B);
   endtask : t_xfer
   task automatic t_nmi;
      int k;
      for (int b = 1; b < 6; b++) begin
         k = (b == 5) ? 2 : b;
         @(posedge CORE_CLK);
         NMI_EN <= 5'(b % 2) << k;
         OSC_STOP <= (b == 1);
         INDEPENDENT_WATCHDOG_UNDERFLOW <= (b == 2);
         VMON1_INT <= (b == 3);
         VMON2_INT <= (b == 4);
         INDEPENDENT_WATCHDOG_REFRESH_ERR <= (b == 5);
         @(posedge CORE_CLK);
         {OSC_STOP, INDEPENDENT_WATCHDOG_UNDERFLOW, VMON1_INT, VMON2_INT, INDEPENDENT_WATCHDOG_REFRESH_ERR} <= 5'h00;
         settle(4);
         chk({NMI_REQ, NMI_STATUS}, {1'(b % 2), 5'h01 << k});
         nclr();
         chk(NMI_STATUS, 5'h00);
      end
      for (int r = 0; r < 2; r++) begin
         for (int t = 0; t < 2; t++) begin
            @(posedge CORE_CLK);
            NMI_EN <= 5'h01;
            NMI_EDGE_RISE <= r[0];
            NMI_FILT_EN <= !r[0];
            NMI_PIN <= t[0];
            settle(12);
            chk({NMI_REQ, NMI_STATUS}, (r == t) ? 16'h0021 : 16'h0000);
            nclr();
         end
      end
   endtask : t_nmi
   task automatic t_pins;
      int n0;
      cfg(CFG_PRIO, 8'h43, 4'h2);
      for (int m = 0; m < 4; m++) begin
         @(posedge CORE_CLK);
         IRQ_MODE[7:6] <= 2'(m);
         IRQ_PIN[3] <= 1'b0;
         n0 = n_got;
         settle(16);
         chk(16'(n_got != n0), 16'(m != DET_RISE));
         @(posedge CORE_CLK);
         IRQ_PIN[3] <= 1'b1;
         n0 = n_got;
         settle(16);
         // Level mode may still take during the filter tail, then must go quiet
         if (m == 0) begin
            quiet(16);
         end else begin
            chk(16'(n_got != n0), 16'(m >= 2));
         end
      end
   endtask : t_pins
   task automatic t_wake;
      @(posedge CORE_CLK);
      LP_MODE <= LP_SLEEP;
      hold <= 1'b1;
      settle(3);
      chk(WAKE_REQ, 1'b0);
      cfg(CFG_CLR, 8'h32, 4'h0);
      @(posedge CORE_CLK);
      LP_MODE <= LP_STBY;
      req(256'h1 << 8'h14);
      settle(4);
      chk(WAKE_REQ, 1'b0);
      chk({CPU_IRQ, CPU_VEC, CPU_LVL}, {1'b1, 8'h14, 4'h3});
      for (int m = 1; m < 3; m++) begin
         @(posedge CORE_CLK);
         LP_MODE <= 2'(m);
         settle(3);
         chk(WAKE_REQ, 1'b1);
      end
      @(posedge CORE_CLK);
      LP_MODE <= LP_STBY;
      IRQ_MODE[7:6] <= DET_LOW;
      IRQ_PIN[3] <= 1'b0;
      settle(10);
      chk(WAKE_REQ, 1'b1);
      @(posedge CORE_CLK);
      LP_MODE <= LP_RUN;
      IRQ_PIN[3] <= 1'b1;
      hold <= 1'b0;
      take(10'h014);
      take(10'h043);
   endtask : t_wake
   ////////////////////////////////////////
   initial begin
      #200000;
      n_mismatch++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      @(negedge CORE_CLK);
      chk({CPU_IRQ, DTC_REQ, DMA_REQ, NMI_REQ, NMI_STATUS, WAKE_REQ}, 16'h0000);
      t_prio();
      t_fast();
      t_xfer();
      t_nmi();
      t_pins();
      t_wake();
      conclude();
   end
endmodule : icunm_top_tb
